// ### rtl/scu_cfg.svh
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// Register byte offsets
`define SCU_OFF_CTRL     12'h000
`define SCU_OFF_STAT     12'h004
`define SCU_OFF_TXBUF    12'h008
`define SCU_OFF_RXBUF    12'h00c
`define SCU_OFF_BAUD     12'h010

// Reset values
`define SCU_CTRL_RST     9'h000
`define SCU_STAT_RST     6'h01
`define SCU_BYTE_RST     8'h00
`define SCU_TXSHIFT_RST  11'h7ff

// Asynchronous timing in base ticks (16 per bit)
`define SCU_TICK_LAST    4'hf
`define SCU_SAMPLE_TICK  4'h7

// Frame layout
`define SCU_SYNC_LAST    4'h7
`define SCU_DATA_LAST    4'h8
`define SCU_IDX_PAR      4'h9
`define SCU_BITS_PAR     4'hb
`define SCU_BITS_NOPAR   4'ha

// Window after the last synchronous bit, system clocks
`define SCU_LATE_EXT     2'h3
`define SCU_LATE_INT     2'h2

`endif

// ### rtl/scu_pkg.sv
package scu_pkg;

  typedef struct packed {
    logic parity_odd;
    logic parity_en;
    logic ext_clk;
    logic sync_mode;
    logic tx_end_irq_enable;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic receive_enable_bit;
    logic transmit_enable_bit;
  } scu_ctrl_t;

  typedef struct packed {
    logic tx_complete_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic rx_buffer_full_flag;
    logic tx_buffer_empty_flag;
  } scu_stat_t;

  typedef struct packed {
    logic rx_error_request;
    logic rx_full_request;
    logic tx_empty_request;
    logic tx_end_request;
  } scu_req_t;

  typedef enum logic [2:0] {SCU_IRQ_NONE, SCU_IRQ_RXERR, SCU_IRQ_RXFULL,
                            SCU_IRQ_TXEMPTY, SCU_IRQ_TXEND} scu_irq_t;
  typedef enum logic [0:0] {SCU_TX_IDLE, SCU_TX_RUN} scu_tx_st_t;
  typedef enum logic [1:0] {SCU_RX_IDLE, SCU_RX_RUN, SCU_RX_LATE} scu_rx_st_t;

  typedef struct packed {
    scu_ctrl_t   ctrl;
    scu_stat_t   stat;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_buf;
    logic [7:0]  baud;
    scu_tx_st_t  tx_st;
    logic [10:0] tx_shift;
    logic [3:0]  tx_left;
    logic [3:0]  tx_tick;
    logic        txd;
    scu_rx_st_t  rx_st;
    logic [7:0]  rx_shift;
    logic        rx_par;
    logic [3:0]  rx_idx;
    logic [3:0]  rx_tick;
    logic [1:0]  rx_late;
    logic        sck_lvl;
    logic        sck_oe;
    logic        sck_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    scu_req_t    req;
    scu_irq_t    req_top;
  } scu_state_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } scu_sync_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } scu_tick_t;

endpackage

// ### rtl/scu_sync2.sv
`timescale 1ns/100ps
module scu_sync2 import scu_pkg::*; (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Pins: bit 1 serial clock, bit 0 receive data
  input  wire logic [1:0] pins_in,
  output logic      [1:0] pins_out
);
  scu_sync_t s;
  scu_sync_t n;

  always_comb
  begin
    n.meta   = pins_in;
    n.stable = s.meta;
  end

  // Both lines idle high
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '{meta: 2'h3, stable: 2'h3};
    else
      s <= n;
  end

  assign pins_out = s.stable;
endmodule // scu_sync2

// ### rtl/scu_base_tick.sv
`timescale 1ns/100ps
module scu_base_tick import scu_pkg::*; (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Divisor: one tick every divisor+1 system clocks
  input  wire logic [7:0] divisor_in,
  output logic            tick_out
);
  scu_tick_t s;
  scu_tick_t n;

  always_comb
  begin
    n.tick = (s.cnt == divisor_in);
    n.cnt  = n.tick ? 8'h00 : s.cnt + 8'h01;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '{cnt: 8'h00, tick: 1'b0};
    else
      s <= n;
  end

  assign tick_out = s.tick;
endmodule // scu_base_tick

// ### rtl/scu_serial_irq_flags.sv
// Behaviour
// - four separate requests, gated by enable bits
// - transmit-empty request follows empty flag
// - DMA buffer write clears empty flag
// - receive-full request follows full flag
// - DMA buffer read clears full flag
// - any error flag raises receive-error request
// - completion flag raises transmit-end request
// - priority error, full, empty, end
// - empty flag set on load into shifter
// - buffer writes always accepted, may overwrite
// - overrun sets flag, keeps buffer and full
// - framing/parity errors copy data, full stays clear
// - break keeps receiver running, framing error repeats
// - synchronous transmit waits while errors stand
// - receive disable leaves error flags alone
// - asynchronous receive on sixteen-times base clock
// - sample on eighth base tick after start
// - late disable, external clock: full without copy
// - late disable, internal clock: full without copy
// - receive interrupt enable gates full and error requests
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "scu_cfg.svh"
module scu_serial_irq_flags import scu_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // DMA strobes
  input  wire logic        dma_tx_wr_in,
  input  wire logic [7:0]  dma_tx_data_in,
  input  wire logic        dma_rx_rd_in,
  output logic      [7:0]  dma_rx_data_out,
  // Request lines
  output scu_req_t         req_out,
  output scu_irq_t         req_top_out,
  // Serial pins
  input  wire logic        rxd_in,
  input  wire logic        sck_in,
  output logic             txd_out,
  output logic             sck_out,
  output logic             sck_oe_out
);
  localparam scu_state_t ST_RST = '{ctrl: `SCU_CTRL_RST, stat: `SCU_STAT_RST,
                                    tx_st: SCU_TX_IDLE, rx_st: SCU_RX_IDLE,
                                    tx_shift: `SCU_TXSHIFT_RST, txd: 1'b1,
                                    sck_lvl: 1'b1, sck_prev: 1'b1,
                                    req_top: SCU_IRQ_NONE, default: '0};

  scu_state_t s;
  scu_state_t n;
  logic [1:0] pin_s;
  logic       tick;
  logic       apb_acc;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_txb;
  logic       wr_baud;
  logic       tdr_wr;
  logic       rx_err;
  logic       int_clk;
  logic       run_int;
  logic       sck_rise;
  logic       sck_fall;
  logic       tx_done;
  logic       tx_load;
  logic       rx_cmpl;
  logic       rx_ovr;
  logic       rx_fe;
  logic       rx_pe;
  logic       rx_buffer_full_flag_set;
  logic [2:0] err_v;

  function automatic logic at(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  function automatic logic [10:0] tx_frame(input scu_ctrl_t c, input logic [7:0] d);
    logic p;
    p = ^d ^ c.parity_odd;
    if (c.sync_mode)
      return {3'h7, d};
    if (c.parity_en)
      return {1'b1, p, d, 1'b0};
    return {2'h3, d, 1'b0};
  endfunction

  scu_sync2 u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pins_in    ({sck_in, rxd_in}),
    .pins_out   (pin_s)
  );

  scu_base_tick u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .divisor_in (s.baud),
    .tick_out   (tick)
  );

  always_comb
  begin
    n        = s;
    tx_done  = 1'b0;
    rx_cmpl  = 1'b0;
    rx_fe    = 1'b0;
    rx_pe    = 1'b0;
    rx_buffer_full_flag_set = 1'b0;
    apb_acc  = psel_in & penable_in & s.pready;
    wr_ctrl  = apb_acc & pwrite_in & at(paddr_in, `SCU_OFF_CTRL);
    wr_stat  = apb_acc & pwrite_in & at(paddr_in, `SCU_OFF_STAT);
    wr_txb   = apb_acc & pwrite_in & at(paddr_in, `SCU_OFF_TXBUF);
    wr_baud  = apb_acc & pwrite_in & at(paddr_in, `SCU_OFF_BAUD);
    tdr_wr   = wr_txb | dma_tx_wr_in;
    rx_err   = s.stat.overrun_flag | s.stat.framing_error_flag | s.stat.parity_error_flag;

    // One wait state: pready rises the cycle after penable
    n.pready  = psel_in & penable_in & !s.pready;
    n.pslverr = n.pready & !(at(paddr_in, `SCU_OFF_CTRL) | at(paddr_in, `SCU_OFF_STAT) |
                             at(paddr_in, `SCU_OFF_TXBUF) | at(paddr_in, `SCU_OFF_RXBUF) |
                             at(paddr_in, `SCU_OFF_BAUD));
    if (n.pready)
    begin
      n.prdata = 32'h0000_0000;
      if (at(paddr_in, `SCU_OFF_CTRL))
        n.prdata = {23'h000000, s.ctrl};
      if (at(paddr_in, `SCU_OFF_STAT))
        n.prdata = {26'h0000000, s.stat};
      if (at(paddr_in, `SCU_OFF_TXBUF))
        n.prdata = {24'h000000, s.tx_buf};
      if (at(paddr_in, `SCU_OFF_RXBUF))
        n.prdata = {24'h000000, s.rx_buf};
      if (at(paddr_in, `SCU_OFF_BAUD))
        n.prdata = {24'h000000, s.baud};
    end
    if (wr_ctrl)
      n.ctrl = scu_ctrl_t'(pwdata_in[8:0]);
    if (wr_baud)
      n.baud = pwdata_in[7:0];
    // Buffer writes never wait for the empty flag
    if (wr_txb)
      n.tx_buf = pwdata_in[7:0];
    if (dma_tx_wr_in)
      n.tx_buf = dma_tx_data_in;

    // Clears first, so that any hardware set below wins
    if (wr_stat)
      n.stat = scu_stat_t'(s.stat & pwdata_in[5:0]);
    if (dma_tx_wr_in)
      n.stat.tx_buffer_empty_flag = 1'b0;
    if (dma_rx_rd_in)
      n.stat.rx_buffer_full_flag = 1'b0;
    if (!n.stat.tx_buffer_empty_flag)
      n.stat.tx_complete_flag = 1'b0;

    // Serial clock: driven in internal synchronous mode, idles high
    int_clk  = s.ctrl.sync_mode & !s.ctrl.ext_clk;
    run_int  = (s.tx_st == SCU_TX_RUN) |
               ((s.rx_st == SCU_RX_RUN) & !s.ctrl.transmit_enable_bit &
                !s.stat.rx_buffer_full_flag);
    sck_rise = s.ctrl.ext_clk ? (pin_s[1] & !s.sck_prev) : (tick & !s.sck_lvl);
    sck_fall = s.ctrl.ext_clk ? (!pin_s[1] & s.sck_prev) : (tick & s.sck_lvl & run_int);
    n.sck_prev = pin_s[1];
    n.sck_oe   = int_clk;
    if (int_clk & tick & (run_int | !s.sck_lvl))
      n.sck_lvl = !s.sck_lvl;
    if (!int_clk)
      n.sck_lvl = 1'b1;

    // Transmitter
    unique case (s.tx_st)
      SCU_TX_IDLE:
        tx_done = 1'b0;
      SCU_TX_RUN:
      begin
        if (!s.ctrl.sync_mode)
        begin
          if (tick)
            n.tx_tick = s.tx_tick + 4'h1;
          if (tick & (s.tx_tick == `SCU_TICK_LAST))
          begin
            n.tx_shift = {1'b1, s.tx_shift[10:1]};
            n.tx_left  = s.tx_left - 4'h1;
            tx_done    = (s.tx_left == 4'h1);
          end
        end
        else
        begin
          // Bit 0 is already on the line at load; later bits move on falling edges
          if (sck_fall & (s.tx_left != 4'h0))
            n.tx_shift = {1'b1, s.tx_shift[10:1]};
          if (sck_rise)
          begin
            n.tx_left = s.tx_left + 4'h1;
            tx_done   = (s.tx_left == `SCU_SYNC_LAST);
          end
        end
      end
    endcase
    // A load in the cycle of a buffer write would lose the new byte
    tx_load = s.ctrl.transmit_enable_bit & !s.stat.tx_buffer_empty_flag & !tdr_wr &
              !(s.ctrl.sync_mode & rx_err) & ((s.tx_st == SCU_TX_IDLE) | tx_done);
    if (tx_load)
    begin
      n.tx_shift = tx_frame(s.ctrl, s.tx_buf);
      n.tx_left  = s.ctrl.sync_mode ? 4'h0 :
                   (s.ctrl.parity_en ? `SCU_BITS_PAR : `SCU_BITS_NOPAR);
      n.tx_tick  = 4'h0;
      n.tx_st    = SCU_TX_RUN;
      n.stat.tx_buffer_empty_flag = 1'b1;
    end
    else if (tx_done)
    begin
      n.stat.tx_complete_flag = 1'b1;
      n.tx_st = SCU_TX_IDLE;
    end
    if (!s.ctrl.transmit_enable_bit)
    begin
      n.tx_st    = SCU_TX_IDLE;
      n.tx_shift = `SCU_TXSHIFT_RST;
      n.stat.tx_buffer_empty_flag = 1'b1;
    end
    n.txd = n.tx_shift[0];

    // Receiver
    unique case (s.rx_st)
      SCU_RX_IDLE:
      begin
        n.rx_idx  = 4'h0;
        n.rx_tick = 4'h0;
        // A low level after a frame restarts at once, so a break repeats
        if (s.ctrl.receive_enable_bit & (s.ctrl.sync_mode | (tick & !pin_s[0])))
          n.rx_st = SCU_RX_RUN;
      end
      SCU_RX_RUN:
      begin
        if (!s.ctrl.receive_enable_bit)
          n.rx_st = SCU_RX_IDLE;
        else if (s.ctrl.sync_mode)
        begin
          if (sck_rise)
          begin
            n.rx_shift = {pin_s[0], s.rx_shift[7:1]};
            n.rx_idx   = s.rx_idx + 4'h1;
            if (s.rx_idx == `SCU_SYNC_LAST)
            begin
              n.rx_st   = SCU_RX_LATE;
              n.rx_late = s.ctrl.ext_clk ? `SCU_LATE_EXT : `SCU_LATE_INT;
            end
          end
        end
        else if (tick)
        begin
          n.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `SCU_SAMPLE_TICK)
          begin
            n.rx_idx = s.rx_idx + 4'h1;
            if (s.rx_idx == 4'h0)
            begin
              if (pin_s[0])
                n.rx_st = SCU_RX_IDLE;
            end
            else if (s.rx_idx <= `SCU_DATA_LAST)
              n.rx_shift = {pin_s[0], s.rx_shift[7:1]};
            else if (s.ctrl.parity_en & (s.rx_idx == `SCU_IDX_PAR))
              n.rx_par = pin_s[0];
            else
            begin
              rx_cmpl = 1'b1;
              rx_fe   = !pin_s[0];
              rx_pe   = s.ctrl.parity_en & (^s.rx_shift ^ s.rx_par ^ s.ctrl.parity_odd);
              n.rx_st = SCU_RX_IDLE;
            end
          end
        end
      end
      SCU_RX_LATE:
      begin
        // Disable inside the window: flag set, byte dropped
        if (!s.ctrl.receive_enable_bit)
        begin
          rx_buffer_full_flag_set = 1'b1;
          n.rx_st  = SCU_RX_IDLE;
        end
        else if (s.rx_late == 2'h0)
        begin
          rx_cmpl = 1'b1;
          n.rx_st = SCU_RX_IDLE;
        end
        else
          n.rx_late = s.rx_late - 2'h1;
      end
      default:
        n.rx_st = SCU_RX_IDLE;
    endcase
    rx_ovr = rx_cmpl & n.stat.rx_buffer_full_flag;
    if (rx_cmpl)
    begin
      n.stat.framing_error_flag = n.stat.framing_error_flag | rx_fe;
      n.stat.parity_error_flag  = n.stat.parity_error_flag | rx_pe;
      if (rx_ovr)
        n.stat.overrun_flag = 1'b1;
      else
      begin
        n.rx_buf = s.rx_shift;
        rx_buffer_full_flag_set = !(rx_fe | rx_pe);
      end
    end
    if (rx_buffer_full_flag_set)
      n.stat.rx_buffer_full_flag = 1'b1;

    // Request levels follow the registered flags and enables
    n.req.rx_error_request = n.ctrl.rx_irq_enable & (n.stat.overrun_flag |
                             n.stat.framing_error_flag | n.stat.parity_error_flag);
    n.req.rx_full_request  = n.ctrl.rx_irq_enable & n.stat.rx_buffer_full_flag;
    n.req.tx_empty_request = n.ctrl.tx_irq_enable & n.stat.tx_buffer_empty_flag;
    n.req.tx_end_request   = n.ctrl.tx_end_irq_enable & n.stat.tx_complete_flag;
    if (n.req.rx_error_request)
      n.req_top = SCU_IRQ_RXERR;
    else if (n.req.rx_full_request)
      n.req_top = SCU_IRQ_RXFULL;
    else if (n.req.tx_empty_request)
      n.req_top = SCU_IRQ_TXEMPTY;
    else if (n.req.tx_end_request)
      n.req_top = SCU_IRQ_TXEND;
    else
      n.req_top = SCU_IRQ_NONE;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= ST_RST;
    else
      s <= n;
  end

  // Requests double as DMA triggers; only full and empty should be wired to DMA
  assign req_out         = s.req;
  assign req_top_out     = s.req_top;
  assign prdata_out      = s.prdata;
  assign pready_out      = s.pready;
  assign pslverr_out     = s.pslverr;
  assign dma_rx_data_out = s.rx_buf;
  assign txd_out         = s.txd;
  assign sck_out         = s.sck_lvl;
  assign sck_oe_out      = s.sck_oe;
  assign err_v = {s.stat.overrun_flag, s.stat.framing_error_flag, s.stat.parity_error_flag};

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_txe_level: assert property (
    req_out.tx_empty_request == (s.stat.tx_buffer_empty_flag & s.ctrl.tx_irq_enable))
    else $error("transmit-empty request differs from flag and enable");
  chk_rxf_level: assert property (
    req_out.rx_full_request == (s.stat.rx_buffer_full_flag & s.ctrl.rx_irq_enable))
    else $error("receive-full request differs from flag and enable");
  chk_err_level: assert property (
    req_out.rx_error_request == ((err_v != 3'h0) & s.ctrl.rx_irq_enable))
    else $error("receive-error request differs from error flags");
  chk_tx_complete_flag_level: assert property (
    req_out.tx_end_request == (s.stat.tx_complete_flag & s.ctrl.tx_end_irq_enable))
    else $error("transmit-end request differs from flag and enable");
  chk_dma_tx_clr: assert property (
    (dma_tx_wr_in && s.ctrl.transmit_enable_bit && !wr_ctrl) |=> !s.stat.tx_buffer_empty_flag)
    else $error("DMA buffer write did not clear the empty flag");
  chk_dma_rx_clr: assert property (
    (dma_rx_rd_in && !rx_buffer_full_flag_set) |=> !s.stat.rx_buffer_full_flag)
    else $error("DMA buffer read did not clear the full flag");
  chk_prio_top: assert property (
    (req_out.rx_error_request |-> req_top_out == SCU_IRQ_RXERR) and
    ((req_out.rx_full_request && !req_out.rx_error_request) |-> req_top_out == SCU_IRQ_RXFULL))
    else $error("request priority order broken");
  chk_load_sets: assert property (
    (s.tx_st == SCU_TX_IDLE ##1 s.tx_st == SCU_TX_RUN) |-> s.stat.tx_buffer_empty_flag)
    else $error("load into shifter did not set the empty flag");
  chk_tx_blocked: assert property (
    (s.ctrl.sync_mode && err_v != 3'h0 && s.tx_st == SCU_TX_IDLE) |=> s.tx_st == SCU_TX_IDLE)
    else $error("synchronous transmit started with an error flag set");
  chk_re_keeps: assert property (
    (!s.ctrl.receive_enable_bit && !wr_stat) |=> ((err_v & $past(err_v)) == $past(err_v)))
    else $error("error flag lost without a status write");
  chk_ovr_nocopy: assert property (
    rx_ovr |=> (s.stat.overrun_flag && s.stat.rx_buffer_full_flag &&
                s.rx_buf == $past(s.rx_buf)))
    else $error("overrun copied data or dropped the full flag");
  chk_err_copy: assert property (
    (rx_cmpl && !rx_ovr && (rx_fe || rx_pe)) |=>
      (!s.stat.rx_buffer_full_flag && s.rx_buf == $past(s.rx_shift)))
    else $error("framing or parity error handled wrongly");
  chk_late_full: assert property (
    (s.rx_st == SCU_RX_LATE && !s.ctrl.receive_enable_bit) |=>
      (s.stat.rx_buffer_full_flag && s.rx_buf == $past(s.rx_buf)))
    else $error("late disable did not set full without copy");

  cov_overrun: cover property (rx_ovr);
  cov_break:   cover property (rx_cmpl && rx_fe ##[1:400] rx_cmpl && rx_fe);
  cov_dma_tx:  cover property (dma_tx_wr_in ##[1:20] s.tx_st == SCU_TX_RUN);
  cov_late:    cover property (s.rx_st == SCU_RX_LATE && !s.ctrl.receive_enable_bit);
endmodule // scu_serial_irq_flags

// ### sim/scu_far_end.sv
`timescale 1ns/100ps
module scu_far_end (
  // Serial lines toward the block
  output logic rxd_out,
  output logic sck_out
);
  // One bit is 16 base ticks of two system clocks
  localparam int bit_ns = 128;

  initial
  begin
    rxd_out = 1'b1;
    sck_out = 1'b1;
  end

  // Start, 8 data LSB first, stop; a low stop gives a framing error
  task automatic send_async(input logic [7:0] d, input logic stop, input int gap);
    logic [9:0] f;
    // Callers sit on a clock edge; step off it before touching the lines
    #1;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out = f[i];
      #(bit_ns);
    end
    rxd_out = 1'b1;
    #(bit_ns * gap);
  endtask

  task automatic line_break(input int bits);
    #1;
    rxd_out = 1'b0;
    #(bit_ns * bits);
    rxd_out = 1'b1;
  endtask

  // Clock runs only within the frame and rests high
  task automatic send_sync(input logic [7:0] d);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      sck_out = 1'b0;
      rxd_out = d[i];
      #40;
      sck_out = 1'b1;
      #40;
    end
    rxd_out = ~d[7];
  endtask
endmodule // scu_far_end

// ### sim/tb_serial_irq_error_flag_logic.sv
`timescale 1ns/100ps
`include "scu_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_serial_irq_error_flag_logic import scu_pkg::*; ;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        dma_wr = 1'b0;
  logic [7:0]  dma_wd = 8'h00;
  logic        dma_rd = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, txd, sck_o, sck_oe, rxd, far_sck;
  logic [7:0]  dma_q, d;
  scu_req_t    req;
  scu_irq_t    top;
  wire         sck_w = sck_oe ? sck_o : far_sck;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [65:0] aq[$];
  logic [65:0] e;
  logic [7:0]  dq[$];
  logic [7:0]  b[6];

  always #2 clk = ~clk;

  scu_serial_irq_flags u_scu_serial_irq_flags (
    .clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .dma_tx_wr_in(dma_wr),
    .dma_tx_data_in(dma_wd), .dma_rx_rd_in(dma_rd), .dma_rx_data_out(dma_q),
    .req_out(req), .req_top_out(top), .rxd_in(rxd), .sck_in(sck_w),
    .txd_out(txd), .sck_out(sck_o), .sck_oe_out(sck_oe));

  scu_far_end u_scu_far_end (.rxd_out(rxd), .sck_out(far_sck));

  task automatic stop_test();
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Expected answer noted first; upper half is the compare mask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] x);
    aq.push_back({1'b1, wr ? 32'h0 : 32'hffffffff, x});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic dma_tx(input logic [7:0] v);
    @(posedge clk);
    dma_wr <= 1'b1;
    dma_wd <= v;
    @(posedge clk);
    dma_wr <= 1'b0;
  endtask

  task automatic dma_rx(input logic [7:0] v);
    dq.push_back(v);
    @(posedge clk);
    dma_rd <= 1'b1;
    @(posedge clk);
    dma_rd <= 1'b0;
  endtask

  task automatic wait_req(input int k);
    int n;
    n = 0;
    while (req[k] !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("wait_req", 1'b1, req[k])
  endtask

  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      e = aq.pop_front();
      `CHK("apb", e[32:0], {pslverr, prdata} & e[65:33])
    end
    if (dma_rd)
    begin
      d = dq.pop_front();
      `CHK("dma", d, dma_q)
    end
  end

  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'h93bc));
    foreach (b[i])
      b[i] = 8'($urandom());
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, `SCU_OFF_STAT, 0, {1'b0, 32'h01});
    apb(0, 12'h020, 0, {1'b1, 32'h0});
    apb(1, 12'h024, 32'h5, {1'b1, 32'h0});
    `CHK("req", 4'b0000, req)
    apb(1, `SCU_OFF_BAUD, 32'h1, 33'h0);
    apb(1, `SCU_OFF_CTRL, 32'h1e, 33'h0);
    repeat (2) @(posedge clk);
    `CHK("req", 4'b0010, req)
    `CHK("top", SCU_IRQ_TXEMPTY, top)
    apb(1, `SCU_OFF_CTRL, 32'h1f, 33'h0);
    dma_tx(b[0]);
    repeat (4) @(posedge clk);
    dma_tx(b[1]);
    repeat (3) @(posedge clk);
    `CHK("txe", 1'b0, req.tx_empty_request)
    // Sample each bit of the first frame near its middle
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      `CHK("txd", 1'({1'b1, b[0], 1'b0} >> i), txd)
      repeat (32) @(posedge clk);
    end
    wait_req(1);
    `CHK("tx_complete_flag", 1'b0, req.tx_end_request)
    wait_req(0);
    `CHK("top", SCU_IRQ_TXEMPTY, top)
    u_scu_far_end.send_async(b[2], 1'b1, 0);
    wait_req(2);
    `CHK("req", 4'b0111, req)
    `CHK("top", SCU_IRQ_RXFULL, top)
    apb(0, `SCU_OFF_RXBUF, 0, {25'h0, b[2]});
    dma_rx(b[2]);
    repeat (2) @(posedge clk);
    `CHK("rxf", 1'b0, req.rx_full_request)
    u_scu_far_end.send_async(b[3], 1'b1, 2);
    u_scu_far_end.send_async(b[4], 1'b1, 0);
    wait_req(3);
    apb(0, `SCU_OFF_STAT, 0, {1'b0, 32'h27});
    `CHK("top", SCU_IRQ_RXERR, top)
    dma_rx(b[3]);
    apb(1, `SCU_OFF_CTRL, 32'h1d, 33'h0);
    apb(0, `SCU_OFF_STAT, 0, {1'b0, 32'h25});
    apb(1, `SCU_OFF_STAT, 32'h3b, 33'h0);
    apb(1, `SCU_OFF_CTRL, 32'h1f, 33'h0);
    u_scu_far_end.send_async(b[5], 1'b0, 0);
    wait_req(3);
    apb(0, `SCU_OFF_STAT, 0, {1'b0, 32'h29});
    dma_rx(b[5]);
    // Let any frame started by the low stop bit run out
    repeat (700) @(posedge clk);
    // A stray frame may have left the full flag set; start the break clean
    apb(1, `SCU_OFF_STAT, 32'h21, 33'h0);
    fork
      u_scu_far_end.line_break(24);
      begin
        repeat (400) @(posedge clk);
        apb(1, `SCU_OFF_STAT, 32'h37, 33'h0);
        repeat (2) @(posedge clk);
        `CHK("rxe", 1'b0, req.rx_error_request)
        wait_req(3);
      end
    join
    repeat (700) @(posedge clk);
    apb(1, `SCU_OFF_STAT, 32'h01, 33'h0);
    apb(1, `SCU_OFF_CTRL, 32'h7f, 33'h0);
    repeat (8) @(posedge clk);
    dma_tx(b[1]);
    // External clock held back so the DMA load settles first
    repeat (20) @(posedge clk);
    u_scu_far_end.send_sync(b[0]);
    wait_req(2);
    `CHK("tx_complete_flag", 1'b1, req.tx_end_request)
    u_scu_far_end.send_sync(b[4]);
    wait_req(3);
    dma_tx(b[2]);
    repeat (8) @(posedge clk);
    `CHK("txe", 1'b0, req.tx_empty_request)
    dma_rx(b[0]);
    apb(1, `SCU_OFF_STAT, 32'h01, 33'h0);
    wait_req(1);
    apb(1, `SCU_OFF_CTRL, 32'h31, 33'h0);
    repeat (2) @(posedge clk);
    `CHK("sckoe", 1'b1, sck_oe)
    wait_req(0);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule // tb_serial_irq_error_flag_logic
